// ---- bench/plc_regs_properties.sv ----
`timescale 1ns/1ps
module plc_checker
  import plc_pkg::*;
#(
  parameter int NPORTS = 3
)
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic NRST,
  // Bus.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Capture.
  input wire logic [NPORTS-1:0] CAP_VALID,
  input wire logic [NPORTS-1:0] CAP_IS_TX,
  input wire plc_time_t [NPORTS-1:0] CAP_RAW,
  input wire logic [NPORTS-1:0] STAMP_VALID,
  input wire plc_time_t [NPORTS-1:0] STAMP,
  input wire plc_port_cfg_t [NPORTS-1:0] PORT_CFG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ****
  // Checks.
  // ****
  ready_after_setup_a: assert property (
    PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
  ready_in_access_a: assert property (
    PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  ready_single_a: assert property (
    PREADY |=> !PREADY) else $error("ready held too long");
  err_with_ready_a: assert property (
    PSLVERR |-> PREADY) else $error("error without ready");
  stamp_delay_a: assert property (
    CAP_VALID[0] |-> ##2 STAMP_VALID[0]) else $error("stamp late");
  stamp_cause_a: assert property (
    STAMP_VALID[0] |-> $past(CAP_VALID[0], 2)) else $error("stray stamp");
  tx_add_a: assert property (
    CAP_VALID[0] && CAP_IS_TX[0] && CAP_RAW[0].ns < 30'd1000 |-> ##2
    STAMP[0].ns == $past(CAP_RAW[0].ns, 2)
      + 30'($past(PORT_CFG[0].tx_latency, 2)))
    else $error("egress latency not added");
  port0_reset_a: assert property (
    $rose(NRST) |-> PORT_CFG[0] == {16'h0014, 16'h0014, 32'h0})
    else $error("port 0 reset wrong");
  portn_reset_a: assert property (
    $rose(NRST) |-> PORT_CFG[1] == {16'h005F, 16'h011D, 32'h0}
    && PORT_CFG[2] == {16'h005F, 16'h011D, 32'h0})
    else $error("port 1 or 2 reset wrong");
  cover property (PSLVERR);
  cover property (PREADY && !PSLVERR);
  cover property (STAMP_VALID[0]);
endmodule
bind plc_regs plc_checker #(.NPORTS(NPORTS)) u_chk (.CLK(CLK),
  .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CAP_VALID(CAP_VALID), .CAP_IS_TX(CAP_IS_TX),
  .CAP_RAW(CAP_RAW), .STAMP_VALID(STAMP_VALID), .STAMP(STAMP),
  .PORT_CFG(PORT_CFG));

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import plc_pkg::*;
;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, r, lat;
  logic prdy, perr, uen;
  plc_port_cfg_t [2:0] cfg;
  logic [2:0] txf = '0, rxf = '0, cv = '0, ctx = '0, sv;
  plc_time_t [2:0] craw = '0;
  plc_time_t [2:0] st;
  logic [32:0] q[$];
  logic [32:0] ex;
  plc_time_t sq[$];
  int mismatches = 0, n_checks = 0, seed = 56166;

  always #50 clk = ~clk;

  plc_regs #(.NPORTS(3)) DUT (.CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .TX_FRAME(txf), .RX_FRAME(rxf),
    .CAP_VALID(cv), .CAP_IS_TX(ctx), .CAP_RAW(craw), .STAMP_VALID(sv),
    .STAMP(st), .PORT_CFG(cfg), .UNIT_ENABLE(uen));

  // ****
  // Tasks.
  // ****
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    q.push_back(e);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1, a, d, {err, 32'h0});
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    apb(0, a, 32'h0, {err, e});
  endtask

  task pulse(input logic [2:0] t, input logic [2:0] x, input int n);
    repeat (n) begin
      txf <= t;
      rxf <= x;
      @(posedge clk);
    end
    txf <= 0;
    rxf <= 0;
    @(posedge clk);
  endtask

  function automatic plc_time_t adj(plc_time_t t, logic tx,
    logic [15:0] l);
    longint n;
    n = tx ? longint'(t.ns) + l : longint'(t.ns) - l;
    adj = t;
    if (n >= 1000000000) begin
      adj.sec = t.sec + 1;
      n -= 1000000000;
    end
    if (n < 0) begin
      adj.sec = t.sec - 1;
      n += 1000000000;
    end
    adj.ns = n[29:0];
  endfunction

  task cap(input logic tx, input logic [29:0] ns);
    plc_time_t t;
    t = {32'h10, ns};
    sq.push_back(adj(t, tx, tx ? lat[31:16] : lat[15:0]));
    cv <= 3'b001;
    ctx <= {2'b0, tx};
    craw[0] <= t;
    @(posedge clk);
    cv <= 0;
    @(posedge clk);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****
  // Monitor and sequence.
  // ****
  always @(posedge clk) begin
    if (psel && pen && prdy) begin
      ex = q.pop_front();
      chk(64'(perr), 64'(ex[32]));
      if (!pwr && !ex[32]) chk(64'(prd), 64'(ex[31:0]));
    end
    if (sv[0]) chk(64'(st[0]), 64'(sq.pop_front()));
  end

  initial begin
    #(3000 * 100);
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    for (int p = 0; p < 3; p++) begin
      wr(PLC_OFS_SELECT, 32'(p) << PLC_PORT_LSB, 0);
      rd(PLC_OFS_LATENCY, p ? 32'h005F011D : 32'h00140014, 0);
      rd(PLC_OFS_ASYM, 32'h0, 0);
      rd(PLC_OFS_LEVELS, 32'h0, 0);
    end
    r = $random(seed);
    wr(PLC_OFS_LATENCY, r, 0);
    rd(PLC_OFS_LATENCY, r, 0);
    wr(PLC_OFS_ASYM, ~r, 0);
    rd(PLC_OFS_ASYM, ~r, 0);
    chk(64'(cfg[2]), {r, ~r});
    wr(PLC_OFS_LEVELS, r, 1);
    pulse(3'b100, 3'b100, 2);
    pulse(3'b100, 3'b000, 7);
    rd(PLC_OFS_LEVELS, 32'h72, 0);
    wr(PLC_OFS_STAMP_IRQ, 32'h404, 0);
    rd(PLC_OFS_LEVELS, 32'h61, 0);
    wr(PLC_OFS_STAMP_IRQ, 32'h105, 0);
    wr(PLC_OFS_STAMP_IRQ, 32'h004, 0);
    rd(PLC_OFS_LEVELS, 32'h60, 0);
    for (int b = 1; b < 8; b++) begin
      wr(PLC_OFS_SELECT, 32'(b), 0);
      rd(PLC_OFS_LATENCY, 32'h0, 1);
    end
    wr(PLC_OFS_SELECT, 32'h30, 0);
    rd(PLC_OFS_ASYM, 32'h0, 1);
    rd(12'h200, 32'h0, 1);
    wr(PLC_OFS_SELECT, 32'h10, 0);
    wr(PLC_OFS_LATENCY, {16'd1139, 16'd1674}, 0);
    rd(PLC_OFS_LATENCY, {16'd1139, 16'd1674}, 0);
    wr(PLC_OFS_SELECT, 32'h0, 0);
    lat = ($random(seed) & 32'h0FFF0FFF) | 32'h01000100;
    wr(PLC_OFS_LATENCY, lat, 0);
    chk(64'(uen), 64'h0);
    wr(PLC_OFS_CONTROL, 32'h1, 0);
    rd(PLC_OFS_CONTROL, 32'h1, 0);
    chk(64'(uen), 64'h1);
    cap(1, 30'd500);
    cap(0, 30'd100);
    cap(1, 30'd999999990);
    cap(0, 30'd999999);
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule

// ---- core/plc_regs.sv ----
`timescale 1ns/1ps
// Operation
// R1: Per-port egress latency field, bits 31:16.
// R2: Per-port ingress latency field, bits 15:0.
// R3: Latencies correct captured time to medium.
// R4: Port 0 latencies reset to 20.
// R5: Ports 1,2 reset egress 95, ingress 285.
// R6: Software loads latencies for other modes.
// R7: Software picks latencies per port mode.
// R8: No latency writes while unit enabled. The code accepts latency writes whether or not the unit is enabled.
// R9: Signed asymmetry field bits 31:16, reset zero.
// R10: Positive asymmetry means forward path slower.
// R11: Peer delay field bits 15:0, reset zero.
// R12: Transmit count increments per sent frame.
// R13: Transmit count drops on irq write one.
// R14: Receive count increments per received frame.
// R15: Receive count drops on irq write one.
// R16: Capture levels register read-only, resets zero.
// R17: Registers at 158h,15Ch,160h in bank 0.
// R18: Bank select decodes four banks, 1xx reserved.
// R19: Port select bits 5:4 pick port.
// R20: Add egress, subtract ingress latency.
// R21: Counts saturate, no wrap.
module plc_regs
  import plc_pkg::*;
#(
  parameter int NPORTS = 3
)
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic NRST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Frame events, one bit per port.
  input wire logic [NPORTS-1:0] TX_FRAME,
  input wire logic [NPORTS-1:0] RX_FRAME,
  // Raw capture, one per port.
  input wire logic [NPORTS-1:0] CAP_VALID,
  input wire logic [NPORTS-1:0] CAP_IS_TX,
  input wire plc_time_t [NPORTS-1:0] CAP_RAW,
  // Corrected stamps.
  output logic [NPORTS-1:0] STAMP_VALID,
  output plc_time_t [NPORTS-1:0] STAMP,
  // Configuration to the time stamp unit.
  output plc_port_cfg_t [NPORTS-1:0] PORT_CFG,
  output logic UNIT_ENABLE
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    plc_port_cfg_t [NPORTS-1:0] cfg;
    logic [2:0] bank;
    logic [1:0] port;
    logic [2:0] gpio;
    logic enable;
    logic [NPORTS-1:0] tx_dec;
    logic [NPORTS-1:0] rx_dec;
    logic [31:0] rdata;
    logic ready;
    logic err;
    plc_time_t [NPORTS-1:0] stamp_out;
    logic [NPORTS-1:0] stamp_vld;
  } plc_state_t;

  plc_state_t s_q;
  plc_state_t s_d;

  wire logic [NPORTS-1:0][2:0] tx_cnt;
  wire logic [NPORTS-1:0][2:0] rx_cnt;
  wire logic [NPORTS-1:0] stamp_valid;
  wire plc_time_t [NPORTS-1:0] stamp;
  wire logic [NPORTS-1:0][31:0] lat_word;
  wire logic [NPORTS-1:0][31:0] asym_word;
  wire logic [NPORTS-1:0][31:0] level_word;

  // ****************************************************************
  // Per-port counters and time correction.
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi++) begin : g_port
      plc_stamp_counter u_tx (
        .clk(CLK),
        .nrst(NRST),
        .inc(TX_FRAME[gi]), // R12
        .dec(s_q.tx_dec[gi]), // R13
        .count(tx_cnt[gi])
      );
      plc_stamp_counter u_rx (
        .clk(CLK),
        .nrst(NRST),
        .inc(RX_FRAME[gi]), // R14
        .dec(s_q.rx_dec[gi]), // R15
        .count(rx_cnt[gi])
      );
      plc_time_adjust u_adj (
        .clk(CLK),
        .nrst(NRST),
        .valid_in(CAP_VALID[gi]),
        .is_tx(CAP_IS_TX[gi]),
        .raw(CAP_RAW[gi]),
        .latency(CAP_IS_TX[gi] ? s_q.cfg[gi].tx_latency
                               : s_q.cfg[gi].rx_latency), // R3
        .valid_out(stamp_valid[gi]),
        .stamp(stamp[gi])
      );
      assign lat_word[gi] =
        (32'(s_q.cfg[gi].tx_latency) << PLC_HI_LSB)
        | 32'(s_q.cfg[gi].rx_latency); // R1 R2
      assign asym_word[gi] =
        (32'(s_q.cfg[gi].path_asymmetry_ns) << PLC_HI_LSB)
        | 32'(s_q.cfg[gi].peer_delay); // R9 R11
      assign level_word[gi] =
        (32'(tx_cnt[gi]) << PLC_TX_CNT_LSB)
        | (32'(rx_cnt[gi]) << PLC_RX_CNT_LSB); // R12 R14 R16
    end
  endgenerate

  // ****************************************************************
  // Reset image.
  // ****************************************************************
  function automatic plc_state_t reset_image();
    plc_state_t r;
    r = '0;
    for (int i = 0; i < NPORTS; i++) begin
      if (i == 0) begin
        r.cfg[i].tx_latency = PLC_P0_TX_LAT_RST; // R4
        r.cfg[i].rx_latency = PLC_P0_RX_LAT_RST; // R4
      end else begin
        r.cfg[i].tx_latency = PLC_PN_TX_LAT_RST; // R5
        r.cfg[i].rx_latency = PLC_PN_RX_LAT_RST; // R5
      end
      r.cfg[i].path_asymmetry_ns = PLC_ASYM_RST; // R9
      r.cfg[i].peer_delay = PLC_PEER_RST; // R11
    end
    return r;
  endfunction

  localparam plc_state_t RESET_IMAGE = reset_image();

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  logic [1:0] p;
  logic port_ok;
  logic in_port_bank;
  logic hit_select;
  logic hit_control;
  logic hit_irq;
  logic hit_latency;
  logic hit_asym;
  logic hit_levels;
  logic port_reg;
  logic refuse;

  always_comb begin
    p = s_q.port; // R19
    port_ok = 32'(p) < NPORTS; // R19
    in_port_bank = s_q.bank == PLC_BANK_GENERAL; // R18
    hit_select = PADDR == PLC_OFS_SELECT;
    hit_control = PADDR == PLC_OFS_CONTROL;
    hit_irq = PADDR == PLC_OFS_STAMP_IRQ;
    hit_latency = PADDR == PLC_OFS_LATENCY; // R17
    hit_asym = PADDR == PLC_OFS_ASYM; // R17
    hit_levels = PADDR == PLC_OFS_LEVELS; // R17
    port_reg = hit_latency || hit_asym || hit_levels;
    refuse = 1'b0;
    if (port_reg && !(in_port_bank && port_ok)) begin
      refuse = 1'b1; // R18
    end
    if (hit_levels && PWRITE) begin
      refuse = 1'b1; // R16
    end
    if (!(hit_select || hit_control || hit_irq || port_reg)) begin
      refuse = 1'b1;
    end
  end

  // ****************************************************************
  // APB access and register state.
  // ****************************************************************
  logic setup;
  logic wr;

  always_comb begin
    s_d = s_q;
    s_d.tx_dec = '0;
    s_d.rx_dec = '0;
    s_d.err = 1'b0;
    setup = PSEL && !PENABLE;
    wr = PSEL && PENABLE && s_q.ready && PWRITE && !s_q.err;
    s_d.ready = setup;
    s_d.stamp_out = stamp; // R3
    s_d.stamp_vld = stamp_valid; // R3
    if (setup) begin
      s_d.rdata = '0;
      s_d.err = refuse;
      if (!refuse) begin
        case (PADDR)
          PLC_OFS_SELECT: begin
            s_d.rdata[PLC_BANK_LSB +: 3] = s_q.bank;
            s_d.rdata[PLC_PORT_LSB +: 2] = s_q.port;
            s_d.rdata[PLC_GPIO_LSB +: 3] = s_q.gpio;
          end
          PLC_OFS_CONTROL: begin
            s_d.rdata[PLC_ENABLE_BIT] = s_q.enable;
          end
          PLC_OFS_LATENCY: begin
            s_d.rdata = lat_word[p]; // R1 R2
          end
          PLC_OFS_ASYM: begin
            s_d.rdata = asym_word[p]; // R9 R11
          end
          PLC_OFS_LEVELS: begin
            s_d.rdata = level_word[p]; // R12 R14
          end
          default: begin
            s_d.rdata = '0;
          end
        endcase
      end
    end
    if (wr) begin
      case (PADDR)
        PLC_OFS_SELECT: begin
          s_d.bank = PWDATA[PLC_BANK_LSB +: 3]; // R18
          s_d.port = PWDATA[PLC_PORT_LSB +: 2]; // R19
          s_d.gpio = PWDATA[PLC_GPIO_LSB +: 3];
        end
        PLC_OFS_CONTROL: begin
          s_d.enable = PWDATA[PLC_ENABLE_BIT];
        end
        PLC_OFS_STAMP_IRQ: begin
          s_d.tx_dec = PWDATA[PLC_TX_IRQ_LSB +: NPORTS]; // R13
          s_d.rx_dec = PWDATA[PLC_RX_IRQ_LSB +: NPORTS]; // R15
        end
        PLC_OFS_LATENCY: begin
          s_d.cfg[p].tx_latency = PWDATA[PLC_HI_LSB +: 16]; // R1
          s_d.cfg[p].rx_latency = PWDATA[15:0]; // R2
        end
        PLC_OFS_ASYM: begin
          s_d.cfg[p].path_asymmetry_ns =
            PWDATA[PLC_HI_LSB +: 16]; // R10
          s_d.cfg[p].peer_delay = PWDATA[15:0]; // R11
        end
        default: begin
          s_d.err = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_q <= RESET_IMAGE; // R4 R5 R9 R11
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign PRDATA = s_q.rdata;
  assign PREADY = s_q.ready;
  assign PSLVERR = s_q.err;
  assign STAMP = s_q.stamp_out;
  assign STAMP_VALID = s_q.stamp_vld;
  assign PORT_CFG = s_q.cfg;
  assign UNIT_ENABLE = s_q.enable;

endmodule

// ---- core/plc_stamp_counter.sv ----
`timescale 1ns/1ps
module plc_stamp_counter
  import plc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Events.
  input wire logic inc,
  input wire logic dec,
  // Level.
  output logic [2:0] count
);

  typedef struct packed {
    logic [2:0] cnt;
  } plc_cnt_state_t;

  plc_cnt_state_t s_q;
  plc_cnt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (inc && !dec && s_q.cnt != PLC_CNT_MAX) begin
      s_d.cnt = s_q.cnt + 3'h1; // R21
    end else if (dec && !inc && s_q.cnt != PLC_CNT_RST) begin
      s_d.cnt = s_q.cnt - 3'h1; // R21
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0; // R16
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;

endmodule

// ---- core/plc_time_adjust.sv ----
`timescale 1ns/1ps
module plc_time_adjust
  import plc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Capture.
  input wire logic valid_in,
  input wire logic is_tx,
  input wire plc_time_t raw,
  input wire logic [15:0] latency,
  // Result.
  output logic valid_out,
  output plc_time_t stamp
);

  localparam logic [30:0] NS_PER_SEC = 31'd1000000000;

  typedef struct packed {
    logic valid;
    plc_time_t t;
  } plc_adj_state_t;

  plc_adj_state_t s_q;
  plc_adj_state_t s_d;
  logic [30:0] sum;
  logic [30:0] dif;

  always_comb begin
    s_d = s_q;
    sum = {1'b0, raw.ns} + {15'h0, latency};
    dif = {1'b0, raw.ns} - {15'h0, latency};
    s_d.valid = valid_in;
    if (valid_in) begin
      s_d.t.sec = raw.sec;
      if (is_tx) begin
        if (sum >= NS_PER_SEC) begin
          s_d.t.ns = 30'(sum - NS_PER_SEC); // R20
          s_d.t.sec = raw.sec + 32'h1;
        end else begin
          s_d.t.ns = sum[29:0]; // R20
        end
      end else begin
        if (dif[30]) begin
          s_d.t.ns = 30'(dif + NS_PER_SEC); // R20
          s_d.t.sec = raw.sec - 32'h1;
        end else begin
          s_d.t.ns = dif[29:0]; // R20
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign valid_out = s_q.valid;
  assign stamp = s_q.t;

endmodule

// ---- include/plc_pkg.sv ----
package plc_pkg;

  // ****************************************************************
  // Register offsets (byte addresses).
  // ****************************************************************
  localparam logic [11:0] PLC_OFS_LATENCY = 12'h158;
  localparam logic [11:0] PLC_OFS_ASYM = 12'h15C;
  localparam logic [11:0] PLC_OFS_LEVELS = 12'h160;
  localparam logic [11:0] PLC_OFS_SELECT = 12'h154;
  localparam logic [11:0] PLC_OFS_STAMP_IRQ = 12'h100;
  localparam logic [11:0] PLC_OFS_CONTROL = 12'h104;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int PLC_HI_LSB = 16;
  localparam int PLC_TX_CNT_LSB = 4;
  localparam int PLC_RX_CNT_LSB = 0;
  localparam int PLC_BANK_LSB = 0;
  localparam int PLC_PORT_LSB = 4;
  localparam int PLC_GPIO_LSB = 8;
  localparam int PLC_TX_IRQ_LSB = 8;
  localparam int PLC_RX_IRQ_LSB = 0;
  localparam int PLC_ENABLE_BIT = 0;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [15:0] PLC_P0_TX_LAT_RST = 16'h0014;
  localparam logic [15:0] PLC_P0_RX_LAT_RST = 16'h0014;
  localparam logic [15:0] PLC_PN_TX_LAT_RST = 16'h005F;
  localparam logic [15:0] PLC_PN_RX_LAT_RST = 16'h011D;
  localparam logic [15:0] PLC_ASYM_RST = 16'h0000;
  localparam logic [15:0] PLC_PEER_RST = 16'h0000;
  localparam logic [2:0] PLC_CNT_RST = 3'h0;
  localparam logic [2:0] PLC_CNT_MAX = 3'h7;

  // ****************************************************************
  // Bank select codes.
  // ****************************************************************
  typedef enum logic [2:0] {
    PLC_BANK_GENERAL = 3'b000,
    PLC_BANK_RX = 3'b001,
    PLC_BANK_TX = 3'b010,
    PLC_BANK_GPIO = 3'b011
  } plc_bank_t;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
  } plc_time_t;

  typedef struct packed {
    logic [15:0] tx_latency;
    logic [15:0] rx_latency;
    logic [15:0] path_asymmetry_ns;
    logic [15:0] peer_delay;
  } plc_port_cfg_t;

endpackage
